/* File: sfs_pkg.sv */
// Shared constants for the serial flash status-write and read link.
package sfs_pkg;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_FAST_READ = 8'h0b;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_BP_HI = 4;
    localparam int BIT_LOCK = 7;
    localparam logic [7:0] STATUS_KEEP_MASK = 8'h63;
    localparam logic [7:0] STATUS_ZERO_MASK = 8'h60;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int ADDR_BITS = 21;
    localparam int SYS_CLK_MHZ = 125;
    localparam int STATUS_WRITE_TIME_US = 15;
    localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_US * SYS_CLK_MHZ;
    localparam int SCLK_HALF_DIV = 10;
    localparam int MEM_WORDS = 256;
endpackage

/* File: sfs_link_if.sv */
// Interface carrying the four SPI wires between host and flash.
`timescale 1ns/1ps
`default_nettype none
interface sfs_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic wp_n;
    modport flash (input cs_n, sclk, mosi, wp_n, output miso, miso_oe);
    modport host (output cs_n, sclk, mosi, wp_n, input miso, miso_oe);
endinterface
`default_nettype wire

/* File: sfs_flash.sv */
// Flash end: command decoder, status register, protection and read engine.
// What this block does
// - Status write needs write-enable latch set first.
// - Host sends command then one data byte.
// - Status bits 6,5,1,0 unchanged; 6,5 read zero.
// - Select rising off byte boundary discards write.
// - Select rise starts timed cycle, busy held.
// - Status still readable while cycle runs.
// - Cycle completion clears write-enable latch.
// - Status write sets block-protect and lock bits.
// - Hardware protected mode refuses status writes.
// - Lock zero: writes allowed whenever latch set.
// - Lock one, pin high: writes allowed.
// - Lock one, pin low: all writes rejected.
// - Hardware mode entered whichever event first.
// - Only pin high leaves hardware mode.
// - Command, three address bytes, MSB first.
// - Address increments, wraps to zero.
// - Select rising stops data output.
// - Reads rejected while a cycle runs.
// - Top three address bits ignored.
// - Fast read waits one dummy byte.
// - Command codes 01h, 03h, 0Bh, 06h.
// - Busy reads one during any cycle.
`timescale 1ns/1ps
`default_nettype none
module sfs_flash
    import sfs_pkg::*;
#(
    parameter int WRITE_CYCLES = sfs_pkg::STATUS_WRITE_CYCLES
) (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Link to the host.
    sfs_link_if.flash LINK,
    // Memory preload port and protection status.
    input wire logic [7:0] MEM_WR_ADDR,
    input wire logic [7:0] MEM_WR_DATA,
    input wire logic MEM_WR_EN,
    output logic [7:0] STATUS,
    output logic HW_PROTECTED,
    output logic [2:0] BLOCK_PROTECT
);
    import sfs_pkg::*;

    typedef enum logic [2:0] {
        SFS_CMD = 3'b000,
        SFS_ADDR = 3'b001,
        SFS_DUMMY = 3'b011,
        SFS_DATA = 3'b010,
        SFS_WDATA = 3'b110,
        SFS_IGNORE = 3'b111
    } sfs_state_e;

    logic [7:0] mem [MEM_WORDS];
    logic [2:0] cs_sync_reg, sclk_sync_reg, mosi_sync_reg, wp_sync_reg;
    logic cs_n, sclk_rise, sclk_fall, mosi_s, wp_n;
    sfs_state_e state_reg;
    logic [2:0] bit_cnt_reg;
    logic [1:0] byte_cnt_reg;
    logic [7:0] shift_reg, out_reg, cmd_reg, new_status_reg;
    logic [ADDR_BITS-1:0] addr_reg;
    logic [7:0] status_reg;
    logic wr_pending_reg, busy_reg, wel_reg, miso_reg, miso_oe_reg;
    logic [31:0] timer_reg;
    logic [7:0] byte_in;
    logic byte_done, sel_start, sel_end, hw_mode, write_ok;

    // The first stage of each synchroniser feeds only the second.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cs_sync_reg <= 3'h7;
            sclk_sync_reg <= 3'h0;
            mosi_sync_reg <= 3'h0;
            wp_sync_reg <= 3'h7;
        end else begin
            cs_sync_reg <= {cs_sync_reg[1:0], LINK.cs_n};
            sclk_sync_reg <= {sclk_sync_reg[1:0], LINK.sclk};
            mosi_sync_reg <= {mosi_sync_reg[1:0], LINK.mosi};
            wp_sync_reg <= {wp_sync_reg[1:0], LINK.wp_n};
        end
    end

    assign cs_n = cs_sync_reg[1];
    assign sel_start = cs_sync_reg[2] && !cs_sync_reg[1];
    assign sel_end = !cs_sync_reg[2] && cs_sync_reg[1];
    assign sclk_rise = !cs_n && !sclk_sync_reg[2] && sclk_sync_reg[1];
    assign sclk_fall = !cs_n && sclk_sync_reg[2] && !sclk_sync_reg[1];
    assign mosi_s = mosi_sync_reg[1];
    assign wp_n = wp_sync_reg[1];
    assign byte_in = {shift_reg[6:0], mosi_s};
    assign byte_done = sclk_rise && (bit_cnt_reg == 3'h7);
    // Pin low with lock set is hardware mode, in either order of events.
    assign hw_mode = status_reg[BIT_LOCK] && !wp_n;
    // Lock clear ignores the pin; lock set needs the pin high.
    assign write_ok = wel_reg && !hw_mode;

    always_ff @(posedge SYS_CLK) begin
        if (MEM_WR_EN) begin
            mem[MEM_WR_ADDR] <= MEM_WR_DATA;
        end
    end

    // Bit counter and input shifter, restarted by each new selection.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || sel_start) begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= byte_in;
        end
    end

    // Command sequencer.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || sel_start) begin
            state_reg <= SFS_CMD;
            byte_cnt_reg <= 2'h0;
            cmd_reg <= 8'h00;
            addr_reg <= '0;
            wr_pending_reg <= 1'b0;
            new_status_reg <= 8'h00;
        end else if (cs_n) begin
            state_reg <= SFS_CMD;
            wr_pending_reg <= 1'b0;
        end else if (byte_done) begin
            case (state_reg)
                SFS_CMD: begin
                    cmd_reg <= byte_in;
                    byte_cnt_reg <= 2'h0;
                    if ((byte_in == CMD_READ || byte_in == CMD_FAST_READ) && !busy_reg) begin
                        state_reg <= SFS_ADDR;
                    end else if (byte_in == CMD_STATUS_WRITE && write_ok && !busy_reg) begin
                        state_reg <= SFS_WDATA;
                    end else begin
                        state_reg <= SFS_IGNORE;
                    end
                end
                SFS_ADDR: begin
                    addr_reg <= {addr_reg[ADDR_BITS-9:0], byte_in};
                    byte_cnt_reg <= byte_cnt_reg + 2'h1;
                    if (byte_cnt_reg == 2'h2) begin
                        state_reg <= (cmd_reg == CMD_FAST_READ) ? SFS_DUMMY : SFS_DATA;
                    end
                end
                SFS_DUMMY: state_reg <= SFS_DATA;
                SFS_DATA: addr_reg <= addr_reg + 1'b1;
                SFS_WDATA: begin
                    new_status_reg <= byte_in;
                    wr_pending_reg <= 1'b1;
                    state_reg <= SFS_IGNORE;
                end
                default: begin
                    // Extra bytes after the data byte void the status write.
                    wr_pending_reg <= 1'b0;
                end
            endcase
        end else if (sclk_rise) begin
            wr_pending_reg <= 1'b0;
        end
    end

    // Output shifter: loads on the falling edge starting each byte.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || cs_n) begin
            out_reg <= 8'h00;
            miso_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else if (sclk_fall && state_reg == SFS_DATA) begin
            miso_oe_reg <= 1'b1;
            if (bit_cnt_reg == 3'h0) begin
                miso_reg <= mem[addr_reg[7:0]][7];
                out_reg <= {mem[addr_reg[7:0]][6:0], 1'b0};
            end else begin
                miso_reg <= out_reg[7];
                out_reg <= {out_reg[6:0], 1'b0};
            end
        end
    end

    // Timed status write and write-enable latch.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            status_reg <= STATUS_RESET;
            busy_reg <= 1'b0;
            wel_reg <= 1'b0;
            timer_reg <= 32'h0;
        end else if (busy_reg) begin
            if (timer_reg == 32'(WRITE_CYCLES - 1)) begin
                busy_reg <= 1'b0;
                wel_reg <= 1'b0;
                timer_reg <= 32'h0;
            end else begin
                timer_reg <= timer_reg + 32'h1;
            end
        end else if (sel_end && wr_pending_reg && bit_cnt_reg == 3'h0 && write_ok) begin
            busy_reg <= 1'b1;
            // Only lock and protect bits take the new byte.
            status_reg <= (status_reg & STATUS_KEEP_MASK)
                | (new_status_reg & ~STATUS_KEEP_MASK);
        end else if (sel_end && cmd_reg == CMD_WRITE_ENABLE && state_reg == SFS_IGNORE
                     && bit_cnt_reg == 3'h0) begin
            wel_reg <= 1'b1;
        end
    end

    // Status is visible at all times, so busy can be polled.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            STATUS <= STATUS_RESET;
            HW_PROTECTED <= 1'b0;
            BLOCK_PROTECT <= 3'h0;
        end else begin
            STATUS <= (status_reg & ~STATUS_ZERO_MASK & 8'h9c)
                | {6'h0, wel_reg, busy_reg};
            HW_PROTECTED <= hw_mode;
            BLOCK_PROTECT <= status_reg[BIT_BP_HI:BIT_BP_LO];
        end
    end

    assign LINK.miso = miso_reg;
    assign LINK.miso_oe = miso_oe_reg;
endmodule
`default_nettype wire

/* File: sfs_host.sv */
// Host end: issues one SPI command frame from a user request.
`timescale 1ns/1ps
`default_nettype none
module sfs_host
    import sfs_pkg::*;
#(
    parameter int HALF_DIV = sfs_pkg::SCLK_HALF_DIV
) (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Link to the flash.
    sfs_link_if.host LINK,
    // User request: bytes to send, then bytes to read back.
    input wire logic START,
    input wire logic [7:0] CMD,
    input wire logic [23:0] ADDR,
    input wire logic [1:0] ADDR_BYTES,
    input wire logic DUMMY,
    input wire logic [7:0] WDATA,
    input wire logic WDATA_EN,
    input wire logic [7:0] READ_BYTES,
    input wire logic WP_LEVEL,
    // Results.
    output logic BUSY,
    output logic [7:0] RDATA,
    output logic RDATA_VALID
);
    import sfs_pkg::*;

    logic [7:0] tx_reg [6];
    logic [2:0] tx_count_reg, tx_idx_reg;
    logic [7:0] rx_left_reg, rx_shift_reg;
    logic [2:0] bit_reg;
    logic [15:0] div_reg;
    logic active_reg, sclk_reg, cs_reg, mosi_reg, wp_reg;
    logic [1:0] miso_sync_reg;
    logic [2:0] n;

    always_comb begin
        n = 3'h1 + {1'b0, ADDR_BYTES} + {2'b0, DUMMY} + {2'b0, WDATA_EN};
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            miso_sync_reg <= 2'h0;
        end else begin
            miso_sync_reg <= {miso_sync_reg[0], LINK.miso};
        end
    end

    // Sends all bytes MSB first, reads back, and only then lifts select.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            active_reg <= 1'b0;
            sclk_reg <= 1'b0;
            cs_reg <= 1'b1;
            mosi_reg <= 1'b0;
            wp_reg <= 1'b1;
            div_reg <= 16'h0;
            bit_reg <= 3'h0;
            tx_count_reg <= 3'h0;
            tx_idx_reg <= 3'h0;
            rx_left_reg <= 8'h0;
            rx_shift_reg <= 8'h0;
            RDATA <= 8'h0;
            RDATA_VALID <= 1'b0;
            for (int i = 0; i < 6; i++) begin
                tx_reg[i] <= 8'h0;
            end
        end else begin
            wp_reg <= WP_LEVEL;
            RDATA_VALID <= 1'b0;
            if (!active_reg) begin
                if (START) begin
                    tx_reg[0] <= CMD;
                    tx_reg[1] <= (ADDR_BYTES != 2'h0) ? ADDR[23:16] : WDATA;
                    tx_reg[2] <= ADDR[15:8];
                    tx_reg[3] <= ADDR[7:0];
                    tx_reg[4] <= 8'h00;
                    tx_reg[5] <= 8'h00;
                    tx_count_reg <= n;
                    tx_idx_reg <= 3'h0;
                    rx_left_reg <= READ_BYTES;
                    bit_reg <= 3'h0;
                    active_reg <= 1'b1;
                    cs_reg <= 1'b0;
                    mosi_reg <= CMD[7];
                    div_reg <= 16'h0;
                end
            end else if (div_reg == 16'(HALF_DIV - 1)) begin
                div_reg <= 16'h0;
                if (!sclk_reg) begin
                    sclk_reg <= 1'b1;
                    rx_shift_reg <= {rx_shift_reg[6:0], miso_sync_reg[1]};
                end else begin
                    sclk_reg <= 1'b0;
                    bit_reg <= bit_reg + 3'h1;
                    if (bit_reg == 3'h7) begin
                        if (tx_idx_reg >= tx_count_reg) begin
                            // All eight bits were taken on the rises; the fall adds none.
                            RDATA <= rx_shift_reg;
                            RDATA_VALID <= 1'b1;
                            rx_left_reg <= rx_left_reg - 8'h1;
                        end
                        if (tx_idx_reg + 3'h1 < tx_count_reg) begin
                            tx_idx_reg <= tx_idx_reg + 3'h1;
                            mosi_reg <= tx_reg[tx_idx_reg + 3'h1][7];
                        end else if (tx_idx_reg + 3'h1 == tx_count_reg && rx_left_reg != 8'h0) begin
                            tx_idx_reg <= tx_count_reg;
                            mosi_reg <= 1'b0;
                        end else if (tx_idx_reg >= tx_count_reg && rx_left_reg > 8'h1) begin
                            mosi_reg <= 1'b0;
                        end else begin
                            active_reg <= 1'b0;
                            cs_reg <= 1'b1;
                            mosi_reg <= 1'b0;
                        end
                    end else if (tx_idx_reg < tx_count_reg) begin
                        mosi_reg <= tx_reg[tx_idx_reg][3'h6 - bit_reg];
                    end
                end
            end else begin
                div_reg <= div_reg + 16'h1;
            end
        end
    end

    assign BUSY = active_reg;
    assign LINK.cs_n = cs_reg;
    assign LINK.sclk = sclk_reg;
    assign LINK.mosi = mosi_reg;
    assign LINK.wp_n = wp_reg;
endmodule
`default_nettype wire

/* File: sfs_chk.sv */
// Checker for the wires between the host end and the flash end.
`timescale 1ns/1ps
`default_nettype none
module sfs_chk (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Link wires.
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic wp_n
);
    int rises_reg;
    // Counts link clock rises inside a frame, so byte framing can be judged at select rise.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || cs_n) begin
            rises_reg <= 0;
        end else if ($rose(sclk)) begin
            rises_reg <= rises_reg + 1;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_high;
        sclk [*8];
    endsequence
    sequence s_low_pair;
        !sclk [*2];
    endsequence
    property p_sclk_high;
        $rose(sclk) |-> s_high ##[2:4] !sclk;
    endproperty
    property p_cs_fall;
        $fell(cs_n) |-> s_low_pair;
    endproperty
    property p_sclk_idle;
        cs_n && $past(cs_n) |-> !sclk;
    endproperty
    property p_mosi_hold;
        sclk && $past(sclk) |-> $stable(mosi);
    endproperty
    property p_miso_hold;
        miso_oe && $past(miso_oe) && sclk && $past(sclk) |-> $stable(miso);
    endproperty
    property p_oe_off;
        cs_n [*6] |-> !miso_oe;
    endproperty
    property p_oe_start;
        $rose(miso_oe) |-> !cs_n && rises_reg >= 32;
    endproperty
    property p_whole_bytes;
        $rose(cs_n) |-> rises_reg[2:0] == 3'h0 && rises_reg >= 8;
    endproperty
    a_sclk_high: assert property (p_sclk_high)
        else $error("link clock high phase wrong");
    a_cs_fall: assert property (p_cs_fall)
        else $error("clock not low at select fall");
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("clock moves outside frame");
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("mosi moved while clock high");
    a_miso_hold: assert property (p_miso_hold)
        else $error("miso moved while clock high");
    a_oe_off: assert property (p_oe_off)
        else $error("miso driven after deselect");
    a_oe_start: assert property (p_oe_start)
        else $error("miso driven before address done");
    a_whole_bytes: assert property (p_whole_bytes)
        else $error("frame not whole bytes");
endmodule
`default_nettype wire

/* File: sfs_bench.sv */
// Bench joining host and flash ends, plus a hand-driven second flash.
`timescale 1ns/1ps
`default_nettype none
module spi_flash_status_write_and_read_bench;
    import sfs_pkg::*;
    logic sys_clk = 0, rst_n = 0, start = 0, dummy = 0, wen = 0, wp = 1;
    logic mwe = 0, oe_seen = 0;
    logic [7:0] cmd = 0, wdata = 0, nrd = 0, ma = 0, md = 0;
    logic [7:0] rdata, st, st2;
    logic [23:0] addr = 0;
    logic [1:0] ab = 0;
    logic busy, rvalid, hwp;
    logic [2:0] bp;
    logic [7:0] rq[$];
    int failures = 0, comparisons = 0;
    sfs_link_if link();
    sfs_link_if link2();
    sfs_flash #(.WRITE_CYCLES(400)) sfs_flash_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(link),
        .MEM_WR_ADDR(ma), .MEM_WR_DATA(md), .MEM_WR_EN(mwe), .STATUS(st),
        .HW_PROTECTED(hwp), .BLOCK_PROTECT(bp));
    // The second flash faces a bit-banged driver that can cut a frame short.
    sfs_flash #(.WRITE_CYCLES(400)) sfs_flash_b_i (.SYS_CLK(sys_clk), .RST_N(rst_n),
        .LINK(link2), .MEM_WR_ADDR(8'h00), .MEM_WR_DATA(8'h00), .MEM_WR_EN(1'b0),
        .STATUS(st2), .HW_PROTECTED(), .BLOCK_PROTECT());
    sfs_host sfs_host_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(link), .START(start),
        .CMD(cmd), .ADDR(addr), .ADDR_BYTES(ab), .DUMMY(dummy), .WDATA(wdata),
        .WDATA_EN(wen), .READ_BYTES(nrd), .WP_LEVEL(wp), .BUSY(busy), .RDATA(rdata),
        .RDATA_VALID(rvalid));
    sfs_chk sfs_chk_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .cs_n(link.cs_n),
        .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe),
        .wp_n(link.wp_n));
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (rvalid === 1'b1) rq.push_back(rdata);
    always @(posedge sys_clk) if (link.miso_oe === 1'b1) oe_seen <= 1'b1;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic frame(input logic [7:0] c, input logic [23:0] a, input logic [1:0] b,
                         input logic d, input logic [7:0] w, input logic e, input logic [7:0] n);
        int t;
        t = 0;
        cmd <= c;
        addr <= a;
        ab <= b;
        dummy <= d;
        wdata <= w;
        wen <= e;
        nrd <= n;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        repeat (2) @(posedge sys_clk);
        while (busy !== 1'b0 && t < 3000) begin
            @(posedge sys_clk);
            t++;
        end
        // A frame that never ends is a hang, counted like any mismatch.
        if (busy !== 1'b0) failures++;
        // The flash sees select rise only after its synchroniser lag.
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic sw(input logic [7:0] v);
        frame(CMD_WRITE_ENABLE, 24'h0, 2'h0, 1'b0, 8'h00, 1'b0, 8'h00);
        frame(CMD_STATUS_WRITE, 24'h0, 2'h0, 1'b0, v, 1'b1, 8'h00);
        repeat (450) @(posedge sys_clk);
    endtask
    task automatic bang(input logic [15:0] v, input int n);
        link2.cs_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            link2.mosi <= v[i];
            repeat (10) @(posedge sys_clk);
            link2.sclk <= 1'b1;
            repeat (10) @(posedge sys_clk);
            link2.sclk <= 1'b0;
        end
        repeat (10) @(posedge sys_clk);
        link2.cs_n <= 1'b1;
        link2.mosi <= ~link2.mosi;
        repeat (450) @(posedge sys_clk);
    endtask
    task automatic t_status;
        check(st, 8'h00);
        frame(CMD_STATUS_WRITE, 24'h0, 2'h0, 1'b0, 8'h9c, 1'b1, 8'h00);
        check(st, 8'h00);
        frame(CMD_WRITE_ENABLE, 24'h0, 2'h0, 1'b0, 8'h00, 1'b0, 8'h00);
        check(st[BIT_WEL], 8'h01);
        frame(CMD_STATUS_WRITE, 24'h0, 2'h0, 1'b0, 8'hff, 1'b1, 8'h00);
        check(st[BIT_BUSY], 8'h01);
        oe_seen <= 1'b0;
        frame(CMD_READ, 24'h0, 2'h3, 1'b0, 8'h00, 1'b0, 8'h01);
        check(oe_seen, 8'h00);
        check(st, 8'h9c);
        check(bp, 8'h07);
    endtask
    task automatic t_protect;
        wp <= 1'b0;
        repeat (10) @(posedge sys_clk);
        check(hwp, 8'h01);
        sw(8'h00);
        check(st, 8'h9e);
        wp <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check(hwp, 8'h00);
        sw(8'h00);
        check(st, 8'h00);
        wp <= 1'b0;
        sw(8'h8c);
        check(st, 8'h8c);
        check(hwp, 8'h01);
        wp <= 1'b1;
    endtask
    task automatic t_read;
        for (int i = 0; i < 256; i++) begin
            mwe <= 1'b1;
            ma <= i[7:0];
            md <= i[7:0] ^ 8'h5a;
            @(posedge sys_clk);
        end
        mwe <= 1'b0;
        rq.delete();
        frame(CMD_READ, 24'he000fe, 2'h3, 1'b0, 8'h00, 1'b0, 8'h03);
        check(8'(rq.size()), 8'h03);
        check(rq[0], 8'hfe ^ 8'h5a);
        check(rq[1], 8'hff ^ 8'h5a);
        check(rq[2], 8'h00 ^ 8'h5a);
        check(link.miso_oe, 8'h00);
        rq.delete();
        frame(CMD_FAST_READ, 24'h000010, 2'h3, 1'b1, 8'h00, 1'b0, 8'h02);
        check(rq[0], 8'h10 ^ 8'h5a);
        check(rq[1], 8'h11 ^ 8'h5a);
    endtask
    task automatic t_cut;
        bang(16'h0006, 8);
        check(st2[BIT_WEL], 8'h01);
        bang(16'h00ff, 15);
        check(st2, 8'h02);
        bang(16'h01bc, 16);
        check(st2, 8'h9c);
    endtask
    initial begin
        link2.cs_n = 1'b1;
        link2.sclk = 1'b0;
        link2.mosi = 1'b0;
        link2.wp_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_status;
        t_protect;
        t_read;
        t_cut;
        end_of_test;
    end
    // The whole run needs about 9200 cycles; this allows about five times that.
    initial begin
        #400000;
        failures++;
        end_of_test;
    end
endmodule
`default_nettype wire
